// ===== src/slsd_pkg.sv
package slsd_pkg;

    // register offsets, in register-index units as the port addresses them
    localparam logic [6:0] OFS_DBL_BIAS  = 7'h19;
    localparam logic [6:0] OFS_DBL_EN    = 7'h1B;
    localparam logic [6:0] OFS_DIV_BUF   = 7'h1F;
    localparam logic [6:0] OFS_LD_SRC    = 7'h3B;
    localparam logic [6:0] OFS_LOCK_INDICATOR_DELAY    = 7'h3C;
    localparam logic [6:0] OFS_MRW_HI    = 7'h45;
    localparam logic [6:0] OFS_MRW_LO    = 7'h46;
    localparam logic [6:0] OFS_FR_CTRL   = 7'h47;
    localparam logic [6:0] OFS_FR_DIV    = 7'h48;
    localparam logic [6:0] OFS_FR_DLY_A  = 7'h49;
    localparam logic [6:0] OFS_FR_DLY_B  = 7'h4A;
    localparam logic [6:0] OFS_OUT_DIV   = 7'h4B;
    localparam logic [6:0] OFS_STATUS    = 7'h70;

    // field positions
    localparam int POS_LD_SRC     = 0;
    localparam int POS_DBL_EN     = 0;
    localparam int POS_DIV_BUF    = 14;
    localparam int POS_FR_PRE     = 5;
    localparam int POS_FR_PULSER  = 4;
    localparam int POS_FR_EN      = 3;
    localparam int POS_FR_ROLE    = 2;
    localparam int POS_FR_DIV     = 0;
    localparam int POS_TAP_LO     = 0;
    localparam int POS_TAP_HI     = 6;
    localparam int POS_PULSE_CNT  = 12;
    localparam int POS_OUT_DIV    = 6;

    // constant bits that read back in the containing registers
    localparam logic [15:0] FIX_DBL_EN  = 16'h0002;
    localparam logic [15:0] FIX_DIV_BUF = 16'h03EC;
    localparam logic [15:0] FIX_FR_CTRL = 16'h0001;
    localparam logic [15:0] FIX_OUT_DIV = 16'h0800;

    // reset values
    localparam logic        RST_LD_SRC   = 1'h1;
    localparam logic [15:0] RST_LOCK_INDICATOR_DELAY   = 16'h03E8;
    localparam logic [31:0] RST_MRW      = 32'h0000C350;
    localparam logic [2:0]  RST_FR_PRE   = 3'h4;
    localparam logic [5:0]  RST_TAP1     = 6'h3F;
    localparam logic [15:0] RST_DBL_BIAS = 16'h0624;

    // lock-indicator sequencer, gray along idle, wait, locked
    typedef enum logic [1:0] {
        SLSD_LK_IDLE   = 2'h0,
        SLSD_LK_WAIT   = 2'h1,
        SLSD_LK_LOCKED = 2'h3
    } slsd_lock_st_t;

endpackage : slsd_pkg

// ===== src/slsd_regs.sv
// What this block does
// - lock source: calibration only, or plus tuning
// - lock rises after programmed phase-detector cycle count
// - zero delay count locks right after calibration
// - 32-bit wait holds divider after modulator reset in phase-align fractional mode
// - frame predivide 1,2,4; other codes invalid
// - pulser bit enables burst generation in master
// - role bit: master or repeater; enable bit
// - frame divide ratio is four plus twice code
// - pulser emits programmed pulse count per request
// - doubler enable bit, resets disabled
// - channel divide code table, codes 18-31 reserved
`timescale 1ns/1ps
`default_nettype none

module slsd_regs #(
    parameter int ADDR_W = 7   // register index width
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    // timing strobes
    input  wire logic              pd_tick,
    input  wire logic              ref_tick,
    // lock indication
    input  wire logic              cal_ok,
    input  wire logic              vtune_ok,
    output logic                   lock_out,
    // modulator reset hold-off
    input  wire logic              frac_mode,
    input  wire logic              phase_align_mode,
    input  wire logic              mod_reset_release,
    output logic                   vco_div_hold,
    // frame reference
    input  wire logic              frame_ref_request,
    input  wire logic              frame_ref_in,
    output logic                   frame_ref_out,
    output logic                   frame_ref_enable,
    // doubler and channel divider settings
    output logic                   doubler_enable,
    output logic      [15:0]       doubler_bias_current,
    output logic                   divider_buffer_enable,
    output logic      [9:0]        output_divide_ratio,
    output logic                   cfg_error
);

    // the decode compares against 7-bit offsets, so the index must hold them
    if (ADDR_W < 7)
    begin : g_addr_check
        $error("slsd_regs: ADDR_W below 7 cannot reach all offsets");
    end

    // all state of the block
    typedef struct packed {
        logic                lock_source;        // 0 calibration, 1 plus tuning
        logic [15:0]         lock_delay;         // phase-detector cycles
        logic [31:0]         mod_wait;           // hold-off count
        logic [2:0]          fr_predivide;       // 1, 2 or 4
        logic                fr_pulser;          // burst mode in master
        logic                fr_enable;          // frame ref on
        logic                fr_role;            // 0 master, 1 repeater
        logic [10:0]         fr_divide;          // ratio code
        logic [5:0]          tap1;               // delay taps
        logic [5:0]          tap2;
        logic [5:0]          tap3;
        logic [5:0]          tap4;
        logic [3:0]          fr_pulse_count;     // pulses per request
        logic [15:0]         dbl_bias;           // doubler bias current
        logic                dbl_en;             // doubler enable
        logic                div_buf;            // divider buffer enable
        logic [4:0]          div_code;           // channel divide code
        slsd_pkg::slsd_lock_st_t lk_st;          // lock sequencer
        logic [15:0]         lk_cnt;             // remaining delay ticks
        logic                lock;               // lock indication
        logic [31:0]         hold_cnt;           // remaining hold-off ticks
        logic                hold;               // divider held
        logic [1:0]          pre_cnt;            // predivide counter
        logic [11:0]         half_cnt;           // half-period counter
        logic [3:0]          pulses_left;        // burst pulses still due
        logic                fr_out;             // frame ref level
        logic [9:0]          div_ratio;          // decoded channel ratio
        logic                err;                // invalid configuration
        logic [15:0]         rdata;              // read answer
    } slsd_state_t;

    slsd_state_t state_ff;
    slsd_state_t nxt_state;

    // counts derived from the current settings
    logic [2:0]  pre_ratio;    // predivide as a count, 0 when invalid
    logic        pre_tick;     // one predivided reference tick
    logic [11:0] half_len;     // half period: two plus code

    always_comb
    begin
        pre_ratio = state_ff.fr_predivide;
        if (!(state_ff.fr_predivide == 3'h1 || state_ff.fr_predivide == 3'h2 ||
              state_ff.fr_predivide == 3'h4))
        begin
            pre_ratio = 3'h0;  // invalid code stalls the generator
        end
        pre_tick = ref_tick && (pre_ratio != 3'h0) &&
                   ({1'b0, state_ff.pre_cnt} == pre_ratio - 3'h1);
        half_len = 12'(state_ff.fr_divide) + 12'h002;
    end

    // next-state logic for registers, sequencers and read answer
    always_comb
    begin
        nxt_state = state_ff;

        // register writes; constant bits are not stored, they read back fixed
        if (reg_wr)
        begin
            unique case (7'(reg_addr))
                slsd_pkg::OFS_DBL_BIAS: nxt_state.dbl_bias = reg_wdata;
                slsd_pkg::OFS_DBL_EN:   nxt_state.dbl_en = reg_wdata[slsd_pkg::POS_DBL_EN];
                slsd_pkg::OFS_DIV_BUF:  nxt_state.div_buf = reg_wdata[slsd_pkg::POS_DIV_BUF];
                slsd_pkg::OFS_LD_SRC:   nxt_state.lock_source = reg_wdata[slsd_pkg::POS_LD_SRC];
                slsd_pkg::OFS_LOCK_INDICATOR_DELAY:   nxt_state.lock_delay = reg_wdata;
                slsd_pkg::OFS_MRW_HI:   nxt_state.mod_wait[31:16] = reg_wdata;
                slsd_pkg::OFS_MRW_LO:   nxt_state.mod_wait[15:0] = reg_wdata;
                slsd_pkg::OFS_FR_CTRL:
                begin
                    nxt_state.fr_predivide = reg_wdata[slsd_pkg::POS_FR_PRE +: 3];
                    nxt_state.fr_pulser    = reg_wdata[slsd_pkg::POS_FR_PULSER];
                    nxt_state.fr_enable    = reg_wdata[slsd_pkg::POS_FR_EN];
                    nxt_state.fr_role      = reg_wdata[slsd_pkg::POS_FR_ROLE];
                end
                slsd_pkg::OFS_FR_DIV:   nxt_state.fr_divide = reg_wdata[slsd_pkg::POS_FR_DIV +: 11];
                slsd_pkg::OFS_FR_DLY_A:
                begin
                    nxt_state.tap1 = reg_wdata[slsd_pkg::POS_TAP_LO +: 6];
                    nxt_state.tap2 = reg_wdata[slsd_pkg::POS_TAP_HI +: 6];
                end
                slsd_pkg::OFS_FR_DLY_B:
                begin
                    nxt_state.tap3           = reg_wdata[slsd_pkg::POS_TAP_LO +: 6];
                    nxt_state.tap4           = reg_wdata[slsd_pkg::POS_TAP_HI +: 6];
                    nxt_state.fr_pulse_count = reg_wdata[slsd_pkg::POS_PULSE_CNT +: 4];
                end
                slsd_pkg::OFS_OUT_DIV:  nxt_state.div_code = reg_wdata[slsd_pkg::POS_OUT_DIV +: 5];
                default:                nxt_state.rdata = state_ff.rdata;  // unmapped write ignored
            endcase
        end

        // read answer, valid in the cycle after the strobe only
        nxt_state.rdata = 16'h0000;
        if (reg_rd)
        begin
            unique case (7'(reg_addr))
                slsd_pkg::OFS_DBL_BIAS: nxt_state.rdata = state_ff.dbl_bias;
                slsd_pkg::OFS_DBL_EN:   nxt_state.rdata = slsd_pkg::FIX_DBL_EN |
                                                          16'(state_ff.dbl_en);
                slsd_pkg::OFS_DIV_BUF:  nxt_state.rdata = slsd_pkg::FIX_DIV_BUF |
                                        (16'(state_ff.div_buf) << slsd_pkg::POS_DIV_BUF);
                slsd_pkg::OFS_LD_SRC:   nxt_state.rdata = 16'(state_ff.lock_source);
                slsd_pkg::OFS_LOCK_INDICATOR_DELAY:   nxt_state.rdata = state_ff.lock_delay;
                slsd_pkg::OFS_MRW_HI:   nxt_state.rdata = state_ff.mod_wait[31:16];
                slsd_pkg::OFS_MRW_LO:   nxt_state.rdata = state_ff.mod_wait[15:0];
                slsd_pkg::OFS_FR_CTRL:  nxt_state.rdata = slsd_pkg::FIX_FR_CTRL |
                                        {8'h00, state_ff.fr_predivide, state_ff.fr_pulser,
                                         state_ff.fr_enable, state_ff.fr_role, 2'h0};
                slsd_pkg::OFS_FR_DIV:   nxt_state.rdata = 16'(state_ff.fr_divide);
                slsd_pkg::OFS_FR_DLY_A: nxt_state.rdata = {4'h0, state_ff.tap2, state_ff.tap1};
                slsd_pkg::OFS_FR_DLY_B: nxt_state.rdata = {state_ff.fr_pulse_count,
                                                           state_ff.tap4, state_ff.tap3};
                slsd_pkg::OFS_OUT_DIV:  nxt_state.rdata = slsd_pkg::FIX_OUT_DIV |
                                        (16'(state_ff.div_code) << slsd_pkg::POS_OUT_DIV);
                slsd_pkg::OFS_STATUS:   nxt_state.rdata = {11'h000, state_ff.err,
                                        state_ff.fr_out, state_ff.hold, state_ff.lk_st};
                default:                nxt_state.rdata = 16'h0000;
            endcase
        end

        // lock sequencer; losing calibration drops lock at once
        unique case (state_ff.lk_st)
            slsd_pkg::SLSD_LK_IDLE:
            begin
                if (cal_ok && state_ff.lock_delay == 16'h0000)
                begin
                    nxt_state.lk_st = slsd_pkg::SLSD_LK_LOCKED;
                end
                else if (cal_ok)
                begin
                    nxt_state.lk_st  = slsd_pkg::SLSD_LK_WAIT;
                    nxt_state.lk_cnt = state_ff.lock_delay;
                end
            end
            slsd_pkg::SLSD_LK_WAIT:
            begin
                if (!cal_ok)
                begin
                    nxt_state.lk_st = slsd_pkg::SLSD_LK_IDLE;
                end
                else if (pd_tick && state_ff.lk_cnt == 16'h0001)
                begin
                    nxt_state.lk_st = slsd_pkg::SLSD_LK_LOCKED;
                end
                else if (pd_tick)
                begin
                    nxt_state.lk_cnt = state_ff.lk_cnt - 16'h0001;
                end
            end
            slsd_pkg::SLSD_LK_LOCKED:
            begin
                if (!cal_ok)
                begin
                    nxt_state.lk_st = slsd_pkg::SLSD_LK_IDLE;
                end
            end
            default:
            begin
                nxt_state.lk_st = slsd_pkg::SLSD_LK_IDLE;  // code 2 is illegal
            end
        endcase
        nxt_state.lock = (nxt_state.lk_st == slsd_pkg::SLSD_LK_LOCKED) &&
                         (!state_ff.lock_source || vtune_ok);

        // divider hold-off after modulator reset, only in phase-align fractional
        if (mod_reset_release && frac_mode && phase_align_mode &&
            state_ff.mod_wait != 32'h0000_0000)
        begin
            nxt_state.hold_cnt = state_ff.mod_wait;
            nxt_state.hold     = 1'b1;
        end
        else if (state_ff.hold && pd_tick)
        begin
            nxt_state.hold_cnt = state_ff.hold_cnt - 32'h0000_0001;
            nxt_state.hold     = (state_ff.hold_cnt != 32'h0000_0001);
        end

        // frame reference generator
        if (!state_ff.fr_enable)
        begin
            nxt_state.pre_cnt     = 2'h0;
            nxt_state.half_cnt    = 12'h000;
            nxt_state.pulses_left = 4'h0;
            nxt_state.fr_out      = 1'b0;
        end
        else if (state_ff.fr_role)
        begin
            nxt_state.fr_out = frame_ref_in;  // repeater passes the input
        end
        else
        begin
            if (ref_tick && pre_ratio != 3'h0)
            begin
                nxt_state.pre_cnt = pre_tick ? 2'h0 : state_ff.pre_cnt + 2'h1;
            end
            if (state_ff.fr_pulser && frame_ref_request)
            begin
                nxt_state.pulses_left = state_ff.fr_pulse_count;
            end
            // continuous in plain master, gated by remaining pulses in pulser mode
            if (pre_tick && (!state_ff.fr_pulser || state_ff.pulses_left != 4'h0 ||
                             state_ff.fr_out))
            begin
                // a lowered divide code may leave the count past the new end
                if (state_ff.half_cnt >= half_len - 12'h001)
                begin
                    nxt_state.half_cnt = 12'h000;
                    nxt_state.fr_out   = !state_ff.fr_out;
                    if (state_ff.fr_out && state_ff.fr_pulser && !frame_ref_request &&
                        state_ff.pulses_left != 4'h0)
                    begin
                        nxt_state.pulses_left = state_ff.pulses_left - 4'h1;
                    end
                end
                else
                begin
                    nxt_state.half_cnt = state_ff.half_cnt + 12'h001;
                end
            end
        end

        // channel divide decode; reserved codes leave the ratio at zero
        unique case (state_ff.div_code)
            5'h00:   nxt_state.div_ratio = 10'h002;
            5'h01:   nxt_state.div_ratio = 10'h004;
            5'h02:   nxt_state.div_ratio = 10'h006;
            5'h03:   nxt_state.div_ratio = 10'h008;
            5'h04:   nxt_state.div_ratio = 10'h00C;
            5'h05:   nxt_state.div_ratio = 10'h010;
            5'h06:   nxt_state.div_ratio = 10'h018;
            5'h07:   nxt_state.div_ratio = 10'h020;
            5'h08:   nxt_state.div_ratio = 10'h030;
            5'h09:   nxt_state.div_ratio = 10'h040;
            5'h0A:   nxt_state.div_ratio = 10'h048;
            5'h0B:   nxt_state.div_ratio = 10'h060;
            5'h0C:   nxt_state.div_ratio = 10'h080;
            5'h0D:   nxt_state.div_ratio = 10'h0C0;
            5'h0E:   nxt_state.div_ratio = 10'h100;
            5'h0F:   nxt_state.div_ratio = 10'h180;
            5'h10:   nxt_state.div_ratio = 10'h200;
            5'h11:   nxt_state.div_ratio = 10'h300;
            default: nxt_state.div_ratio = 10'h000;
        endcase

        // invalid predivide or reserved divide code is reported
        nxt_state.err = (pre_ratio == 3'h0) || (state_ff.div_code > 5'h11);
    end

    // single state register, synchronous reset
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_ff              <= '0;
            state_ff.lock_source  <= slsd_pkg::RST_LD_SRC;
            state_ff.lock_delay   <= slsd_pkg::RST_LOCK_INDICATOR_DELAY;
            state_ff.mod_wait     <= slsd_pkg::RST_MRW;
            state_ff.fr_predivide <= slsd_pkg::RST_FR_PRE;
            state_ff.tap1         <= slsd_pkg::RST_TAP1;
            state_ff.dbl_bias     <= slsd_pkg::RST_DBL_BIAS;
            state_ff.div_ratio    <= 10'h002;
            state_ff.lk_st        <= slsd_pkg::SLSD_LK_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from the state register
    assign reg_rdata             = state_ff.rdata;
    assign lock_out              = state_ff.lock;
    assign vco_div_hold          = state_ff.hold;
    assign frame_ref_out         = state_ff.fr_out;
    assign frame_ref_enable      = state_ff.fr_enable;
    assign doubler_enable        = state_ff.dbl_en;
    assign doubler_bias_current  = state_ff.dbl_bias;
    assign divider_buffer_enable = state_ff.div_buf;
    assign output_divide_ratio   = state_ff.div_ratio;
    assign cfg_error             = state_ff.err;

endmodule // slsd_regs

`default_nettype wire

// ===== dv/slsd_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none

module slsd_regs_sva (
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // register port
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // lock and hold-off
    input wire logic        cal_ok,
    input wire logic        lock_out,
    input wire logic        pd_tick,
    input wire logic        frac_mode,
    input wire logic        phase_align_mode,
    input wire logic        mod_reset_release,
    input wire logic        vco_div_hold,
    // frame reference and divider
    input wire logic        frame_ref_enable,
    input wire logic        frame_ref_out,
    input wire logic [15:0] doubler_bias_current,
    input wire logic [9:0]  output_divide_ratio,
    input wire logic        cfg_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // read data only in the cycle after a read strobe
    rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its slot");
    reset_value_a: assert property ($rose(nrst) |-> doubler_bias_current == 16'h0624
        && output_divide_ratio == 10'h002 && !lock_out && !vco_div_hold)
        else $error("output not at reset value");
    lock_drop_a: assert property (!cal_ok |=> !lock_out)
        else $error("lock kept without calibration");
    lock_cause_a: assert property ($rose(lock_out) |-> $past(cal_ok))
        else $error("lock rose without calibration");
    // hold-off only starts on a release in phase-align fractional mode
    hold_start_a: assert property ($rose(vco_div_hold)
        |-> $past(mod_reset_release && frac_mode && phase_align_mode))
        else $error("hold started without cause");
    hold_keep_a: assert property (vco_div_hold && !pd_tick |=> vco_div_hold)
        else $error("hold dropped between ticks");
    ref_off_a: assert property (!frame_ref_enable |=> !frame_ref_out)
        else $error("frame output while disabled");
    ratio_table_a: assert property (output_divide_ratio inside {10'h000, 10'h002,
        10'h004, 10'h006, 10'h008, 10'h00C, 10'h010, 10'h018, 10'h020, 10'h030, 10'h040,
        10'h048, 10'h060, 10'h080, 10'h0C0, 10'h100, 10'h180, 10'h200, 10'h300})
        else $error("ratio outside table");
    reserved_code_a: assert property (output_divide_ratio == 10'h000 |-> cfg_error)
        else $error("reserved code not flagged");

    // main scenarios
    cover property ($rose(lock_out));
    cover property ($fell(vco_div_hold));
    cover property ($rose(cfg_error));
endmodule // slsd_regs_sva

bind slsd_regs slsd_regs_sva i_slsd_regs_sva (.clk(clk), .nrst(nrst), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cal_ok(cal_ok), .lock_out(lock_out), .pd_tick(pd_tick),
    .frac_mode(frac_mode), .phase_align_mode(phase_align_mode),
    .mod_reset_release(mod_reset_release), .vco_div_hold(vco_div_hold),
    .frame_ref_enable(frame_ref_enable), .frame_ref_out(frame_ref_out),
    .doubler_bias_current(doubler_bias_current), .output_divide_ratio(output_divide_ratio),
    .cfg_error(cfg_error));

`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // clock, reset, register port
    logic        clk, nrst, reg_wr, reg_rd;
    logic [6:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, doubler_bias_current;
    // block inputs, pd_tick made by the tick process
    logic pd_tick = 1'b0;
    logic ref_tick, cal_ok, vtune_ok, frac_mode, phase_align_mode, mod_reset_release;
    logic frame_ref_request, frame_ref_in, tick_en;
    // block outputs
    logic lock_out, vco_div_hold, frame_ref_out, frame_ref_enable;
    logic doubler_enable, divider_buffer_enable, cfg_error;
    logic [9:0]  output_divide_ratio;
    // bookkeeping and expectation tables
    int num_errors, total_checks, n, p, h;
    int pd_cnt = 0;
    int cyc = 0;
    logic [6:0]  ra [13] = '{7'h19, 7'h1B, 7'h1F, 7'h3B, 7'h3C, 7'h45, 7'h46, 7'h47, 7'h48,
                             7'h49, 7'h4A, 7'h4B, 7'h20};
    logic [15:0] rv [13] = '{16'h0624, 16'h0002, 16'h03EC, 16'h0001, 16'h03E8, 16'h0000,
                             16'hC350, 16'h0081, 16'h0000, 16'h003F, 16'h0000, 16'h0800, 16'h0};
    int rt [18] = '{2, 4, 6, 8, 12, 16, 24, 32, 48, 64, 72, 96, 128, 192, 256, 384, 512, 768};
    int fp [4] = '{1, 2, 4, 1};
    int fc [4] = '{0, 1, 0, 2047};
    int dl [3] = '{0, 1, 3};

    slsd_regs i_slsd_regs (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pd_tick(pd_tick),
        .ref_tick(ref_tick), .cal_ok(cal_ok), .vtune_ok(vtune_ok), .lock_out(lock_out),
        .frac_mode(frac_mode), .phase_align_mode(phase_align_mode),
        .mod_reset_release(mod_reset_release), .vco_div_hold(vco_div_hold),
        .frame_ref_request(frame_ref_request), .frame_ref_in(frame_ref_in),
        .frame_ref_out(frame_ref_out), .frame_ref_enable(frame_ref_enable),
        .doubler_enable(doubler_enable), .doubler_bias_current(doubler_bias_current),
        .divider_buffer_enable(divider_buffer_enable),
        .output_divide_ratio(output_divide_ratio), .cfg_error(cfg_error));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // one tick every fourth cycle leaves room to see lock before the next tick
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        pd_tick <= tick_en && (cyc % 4 == 3);
        if (pd_tick === 1'b1)
            pd_cnt <= pd_cnt + 1;
    end

    task results;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rdc(input logic [6:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    // wait k edges, then let their updates land
    task wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // high time of the frame output, in clock edges
    task hwait(output int hh);
        for (hh = 0; frame_ref_out !== 1'b1 && hh < 9000; hh++) wt(1);
        for (hh = 0; frame_ref_out === 1'b1 && hh < 9000; hh++) wt(1);
    endtask

    task pulse_rel;
        @(posedge clk) mod_reset_release <= 1'b1;
        @(posedge clk) mod_reset_release <= 1'b0;
        #1 p = pd_cnt;
    endtask

    initial
    begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, ref_tick, cal_ok, vtune_ok} = '0;
        {frac_mode, phase_align_mode, mod_reset_release, frame_ref_request} = '0;
        {frame_ref_in, tick_en, num_errors, total_checks} = '0;
        wt(4);
        @(posedge clk) nrst <= 1'b1;
        wt(1);
        chk(doubler_bias_current, 16'h0624);
        chk({6'h00, output_divide_ratio}, 16'h0002);
        for (int i = 0; i < 13; i++) rdc(ra[i], rv[i]);
        $display("test reset values done");
        wr(7'h1B, 16'h0003);
        rdc(7'h1B, 16'h0003);
        wr(7'h1F, 16'h43EC);
        rdc(7'h1F, 16'h43EC);
        wr(7'h19, 16'h0C2B);
        wr(7'h20, 16'hFFFF);
        rdc(7'h20, 16'h0000);
        wt(2);
        chk(doubler_bias_current, 16'h0C2B);
        chk({14'h0, doubler_enable, divider_buffer_enable}, 16'h0003);
        $display("test register access done");
        for (int c = 0; c < 32; c++)
        begin
            wr(7'h4B, 16'h0800 | 16'(c << 6));
            wt(2);
            chk({6'h00, output_divide_ratio}, (c < 18) ? 16'(rt[c]) : 16'h0000);
            chk({15'h0, cfg_error}, {15'h0, c > 17});
        end
        wr(7'h4B, 16'h0800);
        $display("test divide codes done");
        tick_en <= 1'b1;
        vtune_ok <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            wr(7'h3C, 16'(dl[i]));
            while (pd_tick !== 1'b1) wt(1);
            @(posedge clk) cal_ok <= 1'b1;
            #1 p = pd_cnt;
            for (n = 0; lock_out !== 1'b1 && n < 100; n++) wt(1);
            chk(16'(pd_cnt - p), 16'(dl[i]));
            @(posedge clk) cal_ok <= 1'b0;
            wt(3);
            chk({15'h0, lock_out}, 16'h0000);
        end
        // lock source 1 must wait for the tuning check
        @(posedge clk) vtune_ok <= 1'b0;
        @(posedge clk) cal_ok <= 1'b1;
        wt(30);
        chk({15'h0, lock_out}, 16'h0000);
        wr(7'h3B, 16'h0000);
        wt(30);
        chk({15'h0, lock_out}, 16'h0001);
        rdc(7'h70, 16'h0003);
        $display("test lock done");
        wr(7'h46, 16'h0005);
        rdc(7'h46, 16'h0005);
        @(posedge clk) {frac_mode, phase_align_mode} <= 2'b11;
        pulse_rel();
        chk({15'h0, vco_div_hold}, 16'h0001);
        for (n = 0; vco_div_hold === 1'b1 && n < 200; n++) wt(1);
        chk(16'(pd_cnt - p), 16'h0005);
        @(posedge clk) phase_align_mode <= 1'b0;
        pulse_rel();
        chk({15'h0, vco_div_hold}, 16'h0000);
        @(posedge clk) phase_align_mode <= 1'b1;
        wr(7'h46, 16'h0000);
        pulse_rel();
        chk({15'h0, vco_div_hold}, 16'h0000);
        $display("test hold-off done");
        @(posedge clk) ref_tick <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wr(7'h48, 16'(fc[i]));
            wr(7'h47, 16'h0009 | 16'(fp[i] << 5));
            hwait(h);
            hwait(h);
            chk(16'(h), 16'((2 + fc[i]) * fp[i]));
        end
        wr(7'h48, 16'h0000);
        wr(7'h47, 16'h0069);
        wt(3);
        chk({15'h0, cfg_error}, 16'h0001);
        wr(7'h47, 16'h002D);
        @(posedge clk) frame_ref_in <= 1'b1;
        wt(3);
        chk({15'h0, frame_ref_out}, 16'h0001);
        wr(7'h4A, 16'h3000);
        wr(7'h47, 16'h0039);
        rdc(7'h47, 16'h0039);
        wt(20);
        @(posedge clk) frame_ref_request <= 1'b1;
        @(posedge clk) frame_ref_request <= 1'b0;
        n = 0;
        for (int k = 0; k < 200; k++)
        begin
            h = frame_ref_out;
            wt(1);
            n += (h == 0 && frame_ref_out === 1'b1);
        end
        chk(16'(n), 16'h0003);
        wr(7'h47, 16'h0021);
        wt(3);
        chk({14'h0, frame_ref_enable, frame_ref_out}, 16'h0000);
        $display("test frame reference done");
        @(posedge clk) nrst <= 1'b0;
        @(posedge clk) nrst <= 1'b1;
        rdc(7'h3C, 16'h03E8);
        $display("test second reset done");
        results();
    end

    // the tests need some 9000 cycles
    initial
    begin
        #400000;
        num_errors++;
        results();
    end
endmodule // tb_top

`default_nettype wire
